// ===== core/bts_acc_unit.sv
module bts_acc_unit
  import bts_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_b,
  bts_acc_if.unit   acc
);
  logic [ACC_W-1:0] acc_a_reg;
  logic [ACC_W-1:0] acc_b_reg;
  logic [ACC_W-1:0] s2;
  logic [ACC_W-1:0] src1;
  logic [ACC_W:0]   diff;
  logic [ACC_W-1:0] res;

  assign s2   = acc.sel_b ? acc_b_reg : acc_a_reg;
  // Word operand sits in the middle part, low part zero, top sign extended
  assign src1 = acc.src1_from_acc ? (acc.sel_b ? acc_a_reg : acc_b_reg)
              : {{(ACC_W-2*DATA_W){acc.src1_word[DATA_W-1]}}, acc.src1_word, {DATA_W{1'b0}}};
  // Difference only feeds the flags, never an accumulator
  assign diff = {1'b0, s2} - {1'b0, src1};
  assign res  = diff[ACC_W-1:0];

  assign acc.flag_c = diff[ACC_W];
  assign acc.flag_v = (s2[ACC_W-1] ^ src1[ACC_W-1]) & (s2[ACC_W-1] ^ res[ACC_W-1]);
  assign acc.flag_z = (res == '0);
  assign acc.flag_n = res[ACC_W-1];
  // Extension in use when bits 55..47 disagree
  assign acc.flag_e = !((&res[ACC_W-1:2*DATA_W-1]) || !(|res[ACC_W-1:2*DATA_W-1]));
  assign acc.flag_u = ~(res[2*DATA_W-1] ^ res[2*DATA_W-2]);
  assign acc.acc_a  = acc_a_reg;
  assign acc.acc_b  = acc_b_reg;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      acc_a_reg <= '0;
      acc_b_reg <= '0;
    end else if (acc.clear_stb) begin
      if (acc.sel_b) acc_b_reg <= '0;
      else acc_a_reg <= '0;
    end else if (acc.load_stb) begin
      if (acc.load_b) acc_b_reg <= acc.load_data;
      else acc_a_reg <= acc.load_data;
    end
  end
endmodule : bts_acc_unit

// ===== core/bts_exec.sv
// Implementation choices: strobed register access and the placing of the registers.
module bts_exec
  import bts_pkg::*;
#(
  parameter int MV_W = 4
) (
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic              instr_valid,
  input  wire logic [DATA_W-1:0] instr_word,
  input  wire logic [DATA_W-1:0] ext_word,
  input  wire logic [MV_W-1:0]   extra_cycles,
  input  wire logic              move_limit,
  output logic                   instr_ready,
  output logic                   instr_done,
  output logic [1:0]             instr_words,
  output logic                   mem_rd,
  output logic                   mem_wr,
  output logic                   mem_lock,
  output logic                   mem_space,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic [DATA_W-1:0]      mem_wdata,
  input  wire logic [DATA_W-1:0] mem_rdata,
  output logic [REG_W-1:0]       reg_sel,
  input  wire logic [DATA_W-1:0] reg_rdata,
  output logic                   reg_wr,
  output logic [DATA_W-1:0]      reg_wdata,
  output logic [2:0]             agu_sel,
  input  wire logic [ADDR_W-1:0] agu_r,
  input  wire logic [ADDR_W-1:0] agu_n,
  output logic                   agu_wr,
  output logic [ADDR_W-1:0]      agu_wdata,
  input  wire logic              acc_wr,
  input  wire logic              acc_wsel_b,
  input  wire logic [ACC_W-1:0]  acc_wdata,
  output logic [ACC_W-1:0]       acc_a,
  output logic [ACC_W-1:0]       acc_b,
  output logic [SR_W-1:0]        status_word,
  output logic [SP_W-1:0]        stack_ptr,
  input  wire logic [1:0]        sw_addr,
  input  wire logic [DATA_W-1:0] sw_wdata,
  input  wire logic              sw_wr,
  input  wire logic              sw_rd,
  output logic [DATA_W-1:0]      sw_rdata
);
  localparam int CNT_W = MV_W + 3;

  if (MV_W < 1 || MV_W > 8) begin : g_bad_mv_w
    $error("bts_exec: MV_W must lie in 1..8");
  end

  function automatic logic dec_bit(input logic [DATA_W-1:0] w);
    return (w[23:17] == BIT_CLASS_HI) && !w[7] && w[5] && (w[15:14] != FORM_REG || w[6]);
  endfunction : dec_bit

  function automatic logic dec_clr(input logic [DATA_W-1:0] w);
    return (w[7:4] == CLR_HI) && (w[2:0] == CLR_LO);
  endfunction : dec_clr

  function automatic logic dec_cmp(input logic [DATA_W-1:0] w);
    return !w[7] && (w[2:0] == CMP_LO) && (w[6:4] == JJJ_ACC || w[6]);
  endfunction : dec_cmp

  function automatic logic [REG_W-1:0] jjj_reg(input logic [2:0] j);
    unique case (j)
      JJJ_X0:  return REG_X0;
      JJJ_Y0:  return REG_Y0;
      JJJ_X1:  return REG_X1;
      default: return REG_Y1;
    endcase
  endfunction : jjj_reg

  bts_state_e           state_reg;
  bts_state_e           state_next;
  bts_kind_e            kind_reg;
  bts_kind_e            kind_take;
  logic [DATA_W-1:0]    instr_reg;
  logic [ADDR_W-1:0]    addr_reg;
  logic [ADDR_W-1:0]    agu_new_reg;
  logic                 agu_upd_reg;
  logic [DATA_W-1:0]    word_reg;
  logic [CNT_W-1:0]     cnt_reg;
  logic [CNT_W-1:0]     end_reg;
  logic [1:0]           words_reg;
  logic [SR_W-1:0]      status_reg;
  logic [SR_W-1:0]      status_next;
  logic [SP_W-1:0]      sp_reg;
  logic [SP_W-1:0]      sp_next;
  logic                 carry_last_reg;
  logic [DATA_W-1:0]    sw_rdata_reg;

  bts_acc_if acc_bus ();

  bts_acc_unit u_acc (
    .clock (clock),
    .rst_b (rst_b),
    .acc   (acc_bus.unit)
  );

  // Decode at the accepting edge
  wire              take       = instr_valid && instr_ready;
  wire [1:0]        form_take  = instr_word[15:14];
  wire [2:0]        ea_mode    = instr_word[13:11];
  wire              ea_abs     = (instr_word[13:8] == EA_ABS);
  wire [ADDR_W-1:0] r_plus_n   = agu_r + agu_n;
  wire [ADDR_W-1:0] r_minus_n  = agu_r - agu_n;
  wire [ADDR_W-1:0] r_plus_1   = agu_r + ADDR_W'(1);
  wire [ADDR_W-1:0] r_minus_1  = agu_r - ADDR_W'(1);
  wire [ADDR_W-1:0] short_addr = {{(ADDR_W-6){1'b0}}, instr_word[13:8]};

  // Effective address modes and their register update
  wire [ADDR_W-1:0] ea_addr = ea_abs ? ext_word[ADDR_W-1:0]
                            : (ea_mode == EA_INDEXED) ? r_plus_n
                            : (ea_mode == EA_PRE_DEC) ? r_minus_1 : agu_r;
  wire [ADDR_W-1:0] ea_new  = (ea_mode == EA_POST_DEC_N) ? r_minus_n
                            : (ea_mode == EA_POST_INC_N) ? r_plus_n
                            : (ea_mode == EA_POST_INC)   ? r_plus_1 : r_minus_1;
  wire              ea_upd  = !ea_abs && (ea_mode == EA_POST_DEC_N || ea_mode == EA_POST_INC_N
                            || ea_mode == EA_POST_DEC || ea_mode == EA_POST_INC
                            || ea_mode == EA_PRE_DEC);
  wire [ADDR_W-1:0] addr_take = (form_take == FORM_ABS) ? short_addr
                              : (form_take == FORM_IO) ? (IO_BASE | short_addr) : ea_addr;

  assign kind_take = dec_bit(instr_word) ? K_BIT
                   : dec_clr(instr_word) ? K_CLR
                   : dec_cmp(instr_word) ? K_CMP : K_NONE;

  wire [CNT_W-1:0] base_take = (kind_take == K_BIT) ? CNT_W'(BITOP_BASE_CYC)
                             : (kind_take == K_NONE) ? CNT_W'(NONE_BASE_CYC)
                             : CNT_W'(ALU_BASE_CYC);
  wire [CNT_W-1:0] end_take  = base_take + CNT_W'(extra_cycles) - CNT_W'(1);
  // One word, plus the extension word for absolute addressing
  wire [1:0] words_take = (kind_take == K_BIT && form_take == FORM_EA && ea_abs) ? 2'h2 : 2'h1;

  // Decode of the held instruction
  wire [1:0]  form     = instr_reg[15:14];
  wire        is_bit   = (kind_reg == K_BIT);
  wire        probe    = instr_reg[16];
  wire        dest_mem = is_bit && (form != FORM_REG);
  wire        dest_reg = is_bit && (form == FORM_REG);
  wire        dest_sr  = dest_reg && (instr_reg[13:8] == REG_SR);
  wire        dest_stk = dest_reg && (instr_reg[13:8] == REG_STK_HI);
  wire        last_cyc = (cnt_reg == end_reg);
  // Bit numbers past 23 shift the mask out: reserved, no bit hit
  wire [DATA_W-1:0] bit_mask = DATA_W'(1) << instr_reg[4:0];
  wire [DATA_W-1:0] src_word = dest_mem ? mem_rdata : word_reg;
  wire              bit_val  = |(src_word & bit_mask);
  wire              test_cyc = (state_reg == ST_TEST);
  wire              alu_cyc  = (state_reg == ST_ALU);

  // Sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (take) begin
          state_next = (kind_take == K_BIT) ? ST_FETCH
                     : (kind_take == K_NONE) ? ST_HOLD : ST_ALU;
        end
      end
      ST_FETCH: state_next = ST_TEST;
      ST_TEST:  state_next = ST_STORE;
      ST_STORE: state_next = ST_HOLD;
      ST_ALU:   state_next = ST_HOLD;
      ST_HOLD: begin
        if (last_cyc) state_next = ST_IDLE;
      end
      default:  state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= take ? '0 : cnt_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      kind_reg    <= K_NONE;
      instr_reg   <= '0;
      addr_reg    <= '0;
      agu_new_reg <= '0;
      agu_upd_reg <= 1'b0;
      end_reg     <= '0;
      words_reg   <= 2'h1;
    end else if (take) begin
      kind_reg    <= kind_take;
      instr_reg   <= instr_word;
      addr_reg    <= addr_take;
      agu_new_reg <= ea_new;
      agu_upd_reg <= (kind_take == K_BIT) && (form_take == FORM_EA) && ea_upd;
      end_reg     <= end_take;
      words_reg   <= words_take;
    end
  end

  // Operand word: read in fetch, modified in test, written back in store
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      word_reg       <= '0;
      carry_last_reg <= 1'b0;
    end else if (state_reg == ST_FETCH) begin
      word_reg <= dest_sr ? {{(DATA_W-SR_W){1'b0}}, status_reg} : reg_rdata;
    end else if (test_cyc) begin
      word_reg       <= src_word | bit_mask;
      carry_last_reg <= bit_val;
    end
  end

  // Status word: instruction updates override a software write in the same cycle
  always_comb begin
    status_next = status_reg;
    if (sw_wr && sw_addr == SWA_STATUS) status_next = sw_wdata[SR_W-1:0] & SR_IMPL_MASK;
    if (test_cyc && is_bit) begin
      if (dest_sr && !probe) begin
        status_next = status_reg | (bit_mask[SR_W-1:0] & SR_IMPL_MASK);
      end else begin
        status_next = status_reg;
        status_next[CCR_C] = bit_val;
      end
    end
    if (alu_cyc && kind_reg == K_CLR) begin
      status_next = status_reg;
      status_next[CCR_E] = 1'b0;
      status_next[CCR_N] = 1'b0;
      status_next[CCR_V] = 1'b0;
      status_next[CCR_U] = 1'b1;
      status_next[CCR_Z] = 1'b1;
      status_next[CCR_L] = status_reg[CCR_L] | move_limit;
    end
    if (alu_cyc && kind_reg == K_CMP) begin
      status_next = status_reg;
      status_next[CCR_C] = acc_bus.flag_c;
      status_next[CCR_V] = acc_bus.flag_v;
      status_next[CCR_Z] = acc_bus.flag_z;
      status_next[CCR_N] = acc_bus.flag_n;
      status_next[CCR_U] = acc_bus.flag_u;
      status_next[CCR_E] = acc_bus.flag_e;
      status_next[CCR_L] = status_reg[CCR_L] | acc_bus.flag_v | move_limit;
    end
  end

  // Probing the stack top pops the stack
  assign sp_next = (test_cyc && dest_stk && probe) ? sp_reg - SP_W'(1)
                 : (sw_wr && sw_addr == SWA_SP) ? sw_wdata[SP_W-1:0] : sp_reg;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      status_reg <= SR_RESET;
      sp_reg     <= SP_RESET;
    end else begin
      status_reg <= status_next;
      sp_reg     <= sp_next;
    end
  end

  // Software read port, data valid only in the cycle after the strobe
  wire [DATA_W-1:0] info_word = {{(DATA_W-8){1'b0}}, words_reg, carry_last_reg,
                                 !instr_ready, 1'b0, state_reg};
  wire [DATA_W-1:0] sw_mux = (sw_addr == SWA_STATUS) ? {{(DATA_W-SR_W){1'b0}}, status_reg}
                           : (sw_addr == SWA_SP) ? {{(DATA_W-SP_W){1'b0}}, sp_reg}
                           : (sw_addr == SWA_INFO) ? info_word : '0;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) sw_rdata_reg <= '0;
    else sw_rdata_reg <= sw_rd ? sw_mux : '0;
  end

  // Accumulator unit hookup
  assign acc_bus.clear_stb   = alu_cyc && (kind_reg == K_CLR);
  assign acc_bus.cmp_stb     = alu_cyc && (kind_reg == K_CMP);
  assign acc_bus.load_stb    = acc_wr;
  assign acc_bus.load_b      = acc_wsel_b;
  assign acc_bus.load_data   = acc_wdata;
  assign acc_bus.sel_b       = instr_reg[3];
  assign acc_bus.src1_from_acc = (instr_reg[6:4] == JJJ_ACC);
  assign acc_bus.src1_word     = reg_rdata;

  // Memory side: read in fetch, write in store, lock held across both except on a probe, which reads unlocked
  assign mem_rd    = (state_reg == ST_FETCH) && dest_mem;
  assign mem_wr    = (state_reg == ST_STORE) && dest_mem && !probe;
  assign mem_lock  = dest_mem && !probe && (state_reg == ST_FETCH || test_cyc
                   || state_reg == ST_STORE);
  assign mem_space = instr_reg[6];
  assign mem_addr  = addr_reg;
  assign mem_wdata = word_reg;

  // Register side; the status word is written in the status word block instead
  assign reg_sel   = alu_cyc ? jjj_reg(instr_reg[6:4]) : instr_reg[13:8];
  assign reg_wr    = (state_reg == ST_STORE) && dest_reg && !probe && !dest_sr;
  assign reg_wdata = word_reg;

  // Address register update is issued once, in the fetch cycle
  assign agu_sel   = (state_reg == ST_IDLE) ? instr_word[10:8] : instr_reg[10:8];
  assign agu_wr    = (state_reg == ST_FETCH) && agu_upd_reg;
  assign agu_wdata = agu_new_reg;

  assign instr_ready = (state_reg == ST_IDLE);
  assign instr_done  = (state_reg == ST_HOLD) && last_cyc;
  assign instr_words = words_reg;
  assign acc_a       = acc_bus.acc_a;
  assign acc_b       = acc_bus.acc_b;
  assign status_word = status_reg;
  assign stack_ptr   = sp_reg;
  assign sw_rdata    = sw_rdata_reg;
endmodule : bts_exec

// ===== include/bts_acc_if.sv
interface bts_acc_if;
  import bts_pkg::*;
  logic              clear_stb;
  logic              cmp_stb;
  logic              load_stb;
  logic              sel_b;
  logic              load_b;
  logic              src1_from_acc;
  logic [DATA_W-1:0] src1_word;
  logic [ACC_W-1:0]  load_data;
  logic              flag_c;
  logic              flag_v;
  logic              flag_z;
  logic              flag_n;
  logic              flag_u;
  logic              flag_e;
  logic [ACC_W-1:0]  acc_a;
  logic [ACC_W-1:0]  acc_b;

  modport exec (output clear_stb, cmp_stb, load_stb, sel_b, load_b, src1_from_acc, src1_word,
                load_data, input flag_c, flag_v, flag_z, flag_n, flag_u, flag_e, acc_a, acc_b);
  modport unit (input clear_stb, cmp_stb, load_stb, sel_b, load_b, src1_from_acc, src1_word,
                load_data, output flag_c, flag_v, flag_z, flag_n, flag_u, flag_e, acc_a, acc_b);
endinterface : bts_acc_if

// ===== include/bts_pkg.sv
package bts_pkg;
  localparam int DATA_W = 24;
  localparam int ACC_W  = 56;
  localparam int SR_W   = 16;
  localparam int ADDR_W = 16;
  localparam int REG_W  = 6;
  localparam int SP_W   = 6;

  // Bit-manipulation class fields
  localparam logic [6:0] BIT_CLASS_HI  = 7'h05;
  localparam logic [1:0] FORM_ABS      = 2'h0;
  localparam logic [1:0] FORM_EA       = 2'h1;
  localparam logic [1:0] FORM_IO       = 2'h2;
  localparam logic [1:0] FORM_REG      = 2'h3;
  localparam logic [5:0] EA_ABS        = 6'h30;
  localparam logic [2:0] EA_POST_DEC_N = 3'h0;
  localparam logic [2:0] EA_POST_INC_N = 3'h1;
  localparam logic [2:0] EA_POST_DEC   = 3'h2;
  localparam logic [2:0] EA_POST_INC   = 3'h3;
  localparam logic [2:0] EA_PLAIN      = 3'h4;
  localparam logic [2:0] EA_INDEXED    = 3'h5;
  localparam logic [2:0] EA_PRE_DEC    = 3'h7;
  localparam logic [ADDR_W-1:0] IO_BASE = 16'hFFC0;

  // Accumulator class fields
  localparam logic [3:0] CLR_HI = 4'h1;
  localparam logic [2:0] CLR_LO = 3'h3;
  localparam logic [2:0] CMP_LO = 3'h5;
  localparam logic [2:0] JJJ_ACC = 3'h0;
  localparam logic [2:0] JJJ_X0  = 3'h4;
  localparam logic [2:0] JJJ_Y0  = 3'h5;
  localparam logic [2:0] JJJ_X1  = 3'h6;

  // Register codes
  localparam logic [REG_W-1:0] REG_X0  = 6'h04;
  localparam logic [REG_W-1:0] REG_X1  = 6'h05;
  localparam logic [REG_W-1:0] REG_Y0  = 6'h06;
  localparam logic [REG_W-1:0] REG_Y1  = 6'h07;
  localparam logic [REG_W-1:0] REG_SR  = 6'h29;
  localparam logic [REG_W-1:0] REG_STK_HI = 6'h2C;

  // Status word layout
  localparam int CCR_C = 0;
  localparam int CCR_V = 1;
  localparam int CCR_Z = 2;
  localparam int CCR_N = 3;
  localparam int CCR_U = 4;
  localparam int CCR_E = 5;
  localparam int CCR_L = 6;
  localparam logic [SR_W-1:0] SR_IMPL_MASK = 16'hAF7F;
  localparam logic [SR_W-1:0] SR_RESET     = 16'h0300;
  localparam logic [SP_W-1:0] SP_RESET     = 6'h00;

  // Oscillator cycles before the charged extras
  localparam int BITOP_BASE_CYC = 4;
  localparam int ALU_BASE_CYC   = 2;
  localparam int NONE_BASE_CYC  = 1;

  // Software port map
  localparam logic [1:0] SWA_STATUS = 2'h0;
  localparam logic [1:0] SWA_SP     = 2'h1;
  localparam logic [1:0] SWA_INFO   = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_FETCH = 3'h1,
    ST_TEST  = 3'h3,
    ST_STORE = 3'h2,
    ST_HOLD  = 3'h6,
    ST_ALU   = 3'h4
  } bts_state_e;

  typedef enum logic [1:0] {
    K_NONE = 2'h0,
    K_BIT  = 2'h1,
    K_CLR  = 2'h2,
    K_CMP  = 2'h3
  } bts_kind_e;
endpackage : bts_pkg

// ===== tb/bit_test_set_exec_bench.sv
module bit_test_set_exec_bench;
  import bts_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, rst_b, instr_valid, move_limit, sw_wr, sw_rd, acc_wr, acc_wsel_b;
  logic instr_ready, instr_done, mem_rd, mem_wr, mem_lock, mem_space, reg_wr, agu_wr;
  logic [23:0] instr_word, ext_word, mem_rdata, reg_rdata, sw_wdata, sw_rdata, mem_wdata, reg_wdata;
  logic [15:0] mem_addr, agu_r, agu_n, agu_wdata, status_word, aw, msr;
  logic [55:0] acc_wdata, acc_a, acc_b;
  logic [5:0]  reg_sel, stack_ptr, p;
  logic [3:0]  extra_cycles;
  logic [2:0]  agu_sel;
  logic [1:0]  instr_words, sw_addr;
  logic [31:0] seed = 32'hbb3d_68e8;
  logic [23:0] rd, old;
  int n_errors, check_count, lat;

  bts_exec #(.MV_W(4)) dut (.clock, .rst_b, .instr_valid, .instr_word, .ext_word, .extra_cycles,
    .move_limit, .instr_ready, .instr_done, .instr_words, .mem_rd, .mem_wr, .mem_lock,
    .mem_space, .mem_addr, .mem_wdata, .mem_rdata, .reg_sel, .reg_rdata, .reg_wr, .reg_wdata,
    .agu_sel, .agu_r, .agu_n, .agu_wr, .agu_wdata, .acc_wr, .acc_wsel_b, .acc_wdata, .acc_a,
    .acc_b, .status_word, .stack_ptr, .sw_addr, .sw_wdata, .sw_wr, .sw_rd, .sw_rdata);
  bts_mem_model pm (.clock, .mem_rd, .mem_wr, .mem_space, .mem_addr, .mem_wdata, .mem_rdata,
    .reg_sel, .reg_wr, .reg_wdata, .reg_rdata);

  always #20 clock = ~clock;

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task wrap_up();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up

  task chk(input string what, input logic [55:0] exp, input logic [55:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task sw(input logic wr, input logic [1:0] a, input logic [23:0] d);
    sw_wr <= wr;
    sw_rd <= !wr;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge clock);
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
    @(negedge clock);
    rd = sw_rdata;
    @(posedge clock);
  endtask : sw

  // Called just after an edge with the block idle; returns at the done edge
  task run(input logic [23:0] w, input logic [23:0] x, input logic [3:0] e);
    int k;
    instr_valid <= 1'b1;
    instr_word <= w;
    ext_word <= x;
    extra_cycles <= e;
    @(posedge clock);
    instr_valid <= 1'b0;
    k = 0;
    do begin
      @(negedge clock);
      k++;
      if (agu_wr === 1'b1) aw = agu_wdata;
    end while (instr_done !== 1'b1 && k < 40);
    if (k >= 40) begin
      n_errors++;
      wrap_up();
    end
    lat = k;
    @(posedge clock);
  endtask : run

  task bitmem(input logic pr, input logic [1:0] f, input logic [5:0] fld, input logic s,
              input logic [15:0] a, input logic [23:0] x);
    logic [4:0] n;
    logic [3:0] e;
    n = rnd() % 24;
    e = rnd() % 4;
    old = rnd();
    pm.mem[{s, a[15], a[5:0]}] = old;
    run({7'h05, pr, f, fld, 1'b0, s, 1'b1, n}, x, e);
    msr[0] = old[n];
    chk("latency", 4 + e, lat);
    chk("status", msr, status_word);
    chk("memory", pr ? old : old | (24'h00_0001 << n), pm.mem[{s, a[15], a[5:0]}]);
    chk("words", (f == FORM_EA && fld == EA_ABS) ? 2 : 1, instr_words);
  endtask : bitmem

  initial begin
    {clock, instr_valid, move_limit, sw_wr, sw_rd, acc_wr, acc_wsel_b, sw_addr} = '0;
    {instr_word, ext_word, sw_wdata, acc_wdata, extra_cycles, agu_n} = '0;
    rst_b = 1'b0;
    agu_r = 16'h0005;
    agu_n = 16'h0003;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    chk("status reset", SR_RESET, status_word);
    sw(1'b1, SWA_STATUS, rnd());
    msr = sw_wdata[15:0] & SR_IMPL_MASK;
    sw(1'b0, SWA_STATUS, 24'h00_0000);
    chk("status read", msr, rd);
    sw(1'b0, 2'h3, 24'h00_0000);
    chk("unmapped read", 0, rd);
    $display("software port test done");
    for (int i = 0; i < 12; i++) begin
      p = rnd();
      bitmem(i[0], i[1] ? FORM_IO : FORM_ABS, p, i[2], i[1] ? (16'hffc0 | p) : {10'h000, p}, 0);
    end
    bitmem(1'b0, FORM_EA, EA_ABS, 1'b1, 16'h0021, 24'h00_0021);
    bitmem(1'b1, FORM_EA, {EA_POST_INC, 3'h0}, 1'b0, 16'h0005, 0);
    chk("address update", 16'h0006, aw);
    bitmem(1'b0, FORM_EA, {EA_POST_INC_N, 3'h0}, 1'b1, 16'h0005, 0);
    chk("offset update", 16'h0008, aw);
    bitmem(1'b1, FORM_EA, {EA_INDEXED, 3'h0}, 1'b0, 16'h0008, 0);
    $display("memory bit test done");
    for (int n = 0; n < 16; n++) begin
      run({7'h05, 1'b0, FORM_REG, REG_SR, 3'h3, n[4:0]}, 0, 0);
      msr = msr | ((16'h0001 << n) & SR_IMPL_MASK);
      chk("status set", msr, status_word);
    end
    pm.regs[4] = rnd();
    run({7'h05, 1'b1, FORM_REG, REG_X0, 3'h3, 5'h17}, 0, 0);
    msr[0] = pm.regs[4][23];
    chk("probe carry", msr, status_word);
    pm.regs[5] = 24'h00_0000;
    run({7'h05, 1'b0, FORM_REG, REG_X1, 3'h3, 5'h17}, 0, 0);
    msr[0] = 1'b0;
    chk("register set", 24'h80_0000, pm.regs[5]);
    sw(1'b1, SWA_SP, 24'h00_0005);
    old = rnd();
    pm.regs[REG_STK_HI] = old;
    run({7'h05, 1'b1, FORM_REG, REG_STK_HI, 3'h3, 5'h00}, 0, 0);
    msr[0] = old[0];
    chk("stack pointer", 6'h04, stack_ptr);
    chk("stack probe carry", msr, status_word);
    $display("register bit test done");
    sw(1'b1, SWA_STATUS, 24'h00_0000);
    msr = 16'h0000;
    for (int d = 0; d < 2; d++) begin
      acc_wr <= 1'b1;
      acc_wsel_b <= d[0];
      acc_wdata <= {rnd(), rnd()};
      move_limit <= d[0];
      @(posedge clock);
      acc_wr <= 1'b0;
      run({16'h0000, 4'h1, d[0], 3'h3}, 0, d[3:0]);
      msr = (msr & 16'hffc1) | 16'h0014 | {9'h000, d[0], 6'h00};
      chk("clear latency", 2 + d, lat);
      chk("clear value", 0, d ? acc_b : acc_a);
      chk("clear flags", msr, status_word);
    end
    move_limit <= 1'b0;
    acc_wr <= 1'b1;
    acc_wsel_b <= 1'b1;
    acc_wdata <= 56'h00_0000_2000_0000;
    pm.regs[REG_Y0] = 24'h00_0024;
    @(posedge clock);
    acc_wr <= 1'b0;
    run(24'h00_005d, 0, 0);
    msr = {msr[15:6], 6'h19};
    chk("compare flags", msr, status_word);
    chk("compare keeps b", 56'h00_0000_2000_0000, acc_b);
    sw(1'b0, SWA_INFO, 24'h00_0000);
    chk("info word", {16'h0000, 2'h1, old[0], 2'h0, ST_IDLE}, rd);
    $display("accumulator test done");
    wrap_up();
  end
endmodule : bit_test_set_exec_bench

// ===== tb/bts_exec_sva.sv
module bts_exec_sva
  import bts_pkg::*;
#(
  parameter int MV_W = 4
) (
  input wire logic              clock,
  input wire logic              rst_b,
  input wire logic              instr_valid,
  input wire logic [DATA_W-1:0] instr_word,
  input wire logic [MV_W-1:0]   extra_cycles,
  input wire logic              instr_ready,
  input wire logic              instr_done,
  input wire logic              mem_rd,
  input wire logic              mem_wr,
  input wire logic              mem_lock,
  input wire logic              reg_wr,
  input wire logic [ACC_W-1:0]  acc_a,
  input wire logic [SR_W-1:0]   status_word,
  input wire logic [SP_W-1:0]   stack_ptr
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire            take    = instr_valid && instr_ready;
  wire            bitop   = take && instr_word[23:17] == BIT_CLASS_HI && !instr_word[7] && instr_word[5];
  wire            clr     = take && instr_word[7:4] == CLR_HI && instr_word[2:0] == CLR_LO;
  wire            no_ext  = extra_cycles == '0;
  wire            reg_dst = bitop && instr_word[15:14] == FORM_REG && instr_word[6];
  wire [SR_W-1:0] sel_bit = (16'h0001 << instr_word[4:0]) & SR_IMPL_MASK;

  a_lock_write: assert property (mem_wr |-> mem_lock && $past(mem_rd, 2))
    else $error("write without locked read two cycles before");
  a_lock_span: assert property (mem_rd && mem_lock |=> mem_lock ##1 (mem_lock && mem_wr))
    else $error("locked read not followed by locked write");
  a_bit_latency: assert property (bitop && no_ext |-> ##1 !instr_done [*3] ##1 instr_done)
    else $error("bit operation done at wrong cycle");
  a_clear_latency: assert property (clr && no_ext |-> ##1 !instr_done ##1 instr_done)
    else $error("clear done at wrong cycle");
  a_clear_zero: assert property (clr && no_ext && !instr_word[3] |-> ##2 acc_a == '0)
    else $error("accumulator not cleared");
  a_clear_flags: assert property (clr && no_ext |-> ##2 status_word[5:1] == 5'h0a)
    else $error("flags wrong after clear");
  a_probe_silent: assert property (bitop && instr_word[16] |-> ##1 (!mem_wr && !reg_wr && !mem_lock) [*4])
    else $error("probe wrote its operand");
  a_stack_pop: assert property (reg_dst && instr_word[16]
    && instr_word[13:8] == REG_STK_HI && no_ext |-> ##3 stack_ptr == $past(stack_ptr, 3) - 6'h01)
    else $error("stack pointer not decremented");
  a_status_set: assert property (reg_dst && !instr_word[16]
    && instr_word[13:8] == REG_SR && no_ext |-> ##4 status_word == ($past(status_word, 4)
    | $past(sel_bit, 4)))
    else $error("status word set wrongly");
  c_ea_form: cover property (bitop && instr_word[15:14] == FORM_EA);
  c_locked_wr: cover property (mem_wr);
  c_clear_b: cover property (clr && instr_word[3]);
endmodule : bts_exec_sva

bind bts_exec bts_exec_sva #(.MV_W(MV_W)) u_sva (.clock, .rst_b, .instr_valid, .instr_word,
  .extra_cycles, .instr_ready, .instr_done, .mem_rd, .mem_wr, .mem_lock, .reg_wr, .acc_a,
  .status_word, .stack_ptr);

// ===== tb/bts_mem_model.sv
module bts_mem_model
  import bts_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              mem_rd,
  input  wire logic              mem_wr,
  input  wire logic              mem_space,
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic [DATA_W-1:0] mem_wdata,
  output logic [DATA_W-1:0]      mem_rdata,
  input  wire logic [REG_W-1:0]  reg_sel,
  input  wire logic              reg_wr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0]      reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DATA_W-1:0] mem [256];
  logic [DATA_W-1:0] regs [64];
  wire  [7:0]        idx = {mem_space, mem_addr[15], mem_addr[5:0]};
  assign reg_rdata = regs[reg_sel];
  // Released bus toggles so a sample an odd number of cycles late never reads stale data
  always @(posedge clock) begin
    if (mem_wr) mem[idx] <= mem_wdata;
    if (reg_wr) regs[reg_sel] <= reg_wdata;
    mem_rdata <= mem_rd ? mem[idx] : ~mem_rdata;
  end
endmodule : bts_mem_model
